// ===== common/usb_host_ctrl_pkg.sv
// Purpose: Shared constants and types for the USB host endpoint and power control block
// Assumes: 32-bit register bus, one word per register, byte offsets below
// Notes: Speed codes and register layout are shared by all design files
`default_nettype none

package usb_host_ctrl_pkg;
  // ==========================================================
  // Clock and timing
  localparam int CLK_NS = 20;
  localparam int FILTER_NS = 2000;
  localparam int FILTER_CYC = (FILTER_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_EP_SEL = 8'h04;
  localparam logic [7:0] OFF_TOGGLE = 8'h08;
  localparam logic [7:0] OFF_PING = 8'h0c;
  localparam logic [7:0] OFF_SPEED = 8'h10;
  localparam logic [7:0] OFF_EP_STAT = 8'h14;
  localparam logic [7:0] OFF_HUB = 8'h18;
  localparam logic [7:0] OFF_PWR_CFG = 8'h1c;
  localparam logic [7:0] OFF_PWR_CTRL = 8'h20;
  localparam logic [7:0] OFF_PWR_STAT = 8'h24;

  // ==========================================================
  // Field positions
  localparam int MODE_HOST_BIT = 0;
  localparam int SEL_DIR_BIT = 8;
  localparam int TGL_BIT = 0;
  localparam int PING_BIT = 0;
  localparam int SPD_LSB = 0;
  localparam int HUB_ADDR_LSB = 0;
  localparam int HUB_PORT_LSB = 8;
  localparam int HUB_LS_BIT = 16;
  localparam int PC_EN_BIT = 0;
  localparam int PC_DIS_BIT = 1;
  localparam int PC_DET_ON_BIT = 2;
  localparam int PC_DET_OFF_BIT = 3;
  localparam int PC_SES_ON_BIT = 4;
  localparam int PC_SES_OFF_BIT = 5;
  localparam int PS_FAULT_BIT = 0;
  localparam int PS_VBUS_ERR_BIT = 1;
  localparam int PS_PWR_ON_BIT = 2;
  localparam int PS_DET_BIT = 3;
  localparam int PS_SES_BIT = 4;

  // Endpoint direction codes
  localparam logic host_out_direction = 1'b0;
  localparam logic host_in_direction = 1'b1;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    endpoint_low_speed = 2'b00,
    endpoint_full_speed = 2'b01,
    endpoint_high_speed = 2'b10
  } ep_speed_t;

  typedef enum logic [1:0] {
    fault_action_none = 2'b00,
    fault_action_tristate = 2'b01,
    fault_action_drive_low = 2'b10,
    fault_action_drive_high = 2'b11
  } fault_action_t;

  typedef enum logic [1:0] {
    bus_idle = 2'b00,
    bus_write = 2'b01,
    bus_rd_wait = 2'b10,
    bus_rd_done = 2'b11
  } bus_state_t;

  // Per endpoint-direction host settings
  typedef struct packed {
    logic toggle;
    ep_speed_t speed;
    logic [6:0] hub_port;
    logic [6:0] hub_addr;
  } ep_cfg_t;

  // Power configuration word, bit 0 is the fault polarity
  typedef struct packed {
    logic vbus_glitch_filter;
    logic session_mode;
    logic level_high;
    fault_action_t action;
    logic fault_active_high;
  } pwr_cfg_t;

  localparam int PWR_CFG_W = $bits(pwr_cfg_t);

  // Register write strobe with its data
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [31:0] data;
  } reg_wr_t;

  localparam ep_cfg_t EP_CFG_RST = '{1'b0, endpoint_full_speed, 7'h00, 7'h00};
  localparam pwr_cfg_t PWR_CFG_RST = '{1'b0, 1'b0, 1'b0, fault_action_none, 1'b0};
endpackage

`default_nettype wire

// ===== rtl/ahb_reg_slave.sv
// Purpose: AHB-Lite slave front end for the register file
// Assumes: Single word transfers only, hsize not checked
// Notes: Writes take no wait state, reads take one
`default_nettype none

module ahb_reg_slave
  import usb_host_ctrl_pkg::*;
(
  input wire logic mclk_in,            // System clock
  input wire logic rst_in,             // Async reset, active high
  input wire logic hsel_in,            // Slave select
  input wire logic [31:0] haddr_in,    // Address
  input wire logic [1:0] htrans_in,    // Transfer type
  input wire logic hwrite_in,          // Write flag
  input wire logic [2:0] hsize_in,     // Transfer size, unused
  input wire logic [31:0] hwdata_in,   // Write data
  input wire logic hready_in,          // Bus ready
  output logic [31:0] hrdata_out,      // Read data
  output logic hreadyout_out,          // Slave ready
  output logic hresp_out,              // Always OKAY
  output reg_wr_t wr_out,              // Write strobe to registers
  output logic [7:0] rd_addr_out,      // Read address to registers
  input wire logic [31:0] rd_data_in   // Read data from registers
);
  bus_state_t state_q, state_d;
  logic [7:0] addr_q, addr_d;
  logic [31:0] rdata_q, rdata_d;
  logic accept;

  // ==========================================================
  // Phase tracking
  // The wait state lets a write finishing now be seen by the next read
  always_comb begin
    accept = hsel_in & hready_in & htrans_in[1];
    state_d = state_q;
    addr_d = addr_q;
    rdata_d = rdata_q;
    case (state_q)
      bus_rd_wait: begin
        rdata_d = rd_data_in;
        state_d = bus_rd_done;
      end
      default: begin
        state_d = bus_idle;
        if (accept) begin
          addr_d = {haddr_in[7:2], 2'b00};
          state_d = hwrite_in ? bus_write : bus_rd_wait;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= bus_idle;
      addr_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      rdata_q <= rdata_d;
    end
  end

  // Outputs
  assign hreadyout_out = (state_q != bus_rd_wait);
  assign hresp_out = 1'b0;
  assign hrdata_out = rdata_q;
  assign rd_addr_out = addr_q;
  assign wr_out = '{(state_q == bus_write), addr_q, hwdata_in};
endmodule

`default_nettype wire

// ===== rtl/vbus_power_ctrl.sv
// Purpose: External power switch enable, fault sensing and VBUS glitch filter
// Assumes: Pin inputs synchronous to mclk_in
// Notes: Fault flag is sticky until software clears it
`default_nettype none

module vbus_power_ctrl
  import usb_host_ctrl_pkg::*;
#(
  parameter int FILT_CYC = FILTER_CYC
) (
  input wire logic mclk_in,                  // System clock
  input wire logic rst_in,                   // Async reset, active high
  input wire pwr_cfg_t cfg_in,               // Power configuration
  input wire logic host_mode_in,             // Controller in host mode
  input wire logic en_cmd_in,                // Power enable command pulse
  input wire logic dis_cmd_in,               // Power disable command pulse
  input wire logic det_en_in,                // Fault detection enabled
  input wire logic session_in,               // Session enabled
  input wire logic fault_clr_in,             // Fault flag clear pulse
  input wire logic power_fault_input,        // External fault pin
  input wire logic vbus_valid_in,            // Raw VBUS valid level
  output logic ext_power_enable_out,         // Power enable pin level
  output logic ext_power_enable_oe_n_out,    // Low while driving the pin
  output logic fault_out,                    // Sticky fault flag
  output logic pwr_on_out,                   // Manual power state
  output logic vbus_err_out                  // Filtered VBUS error
);
  localparam int CW = $clog2(FILT_CYC + 1);
  localparam logic [CW-1:0] CNT_MAX = CW'(FILT_CYC);

  logic pwr_on_q, pwr_on_d, fault_q, fault_d, epen_q, epen_d;
  logic oe_n_q, oe_n_d, err_q, err_d, sensed, active;
  logic [CW-1:0] cnt_q, cnt_d;

  // ==========================================================
  // Fault sensing and pin drive
  always_comb begin
    sensed = det_en_in & (power_fault_input == cfg_in.fault_active_high); // see [R10] [R17] [R19]
    fault_d = sensed | (fault_q & ~fault_clr_in); // see [R20]
    pwr_on_d = pwr_on_q;
    if (host_mode_in & en_cmd_in) begin
      pwr_on_d = 1'b1; // see [R16]
    end else if (host_mode_in & dis_cmd_in) begin
      pwr_on_d = 1'b0; // see [R15]
    end
    // Session source only exists on OTG parts, the top forces it off elsewhere
    active = cfg_in.session_mode ? session_in : pwr_on_q; // see [R13]
    epen_d = active ? cfg_in.level_high : ~cfg_in.level_high; // see [R12]
    oe_n_d = 1'b0;
    if (fault_q) begin
      case (cfg_in.action) // see [R11]
        fault_action_tristate: begin
          oe_n_d = 1'b1;
          epen_d = 1'b0;
        end
        fault_action_drive_low: epen_d = 1'b0;
        fault_action_drive_high: epen_d = 1'b1;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // VBUS glitch filter: a drop must last FILT_CYC cycles to count
  always_comb begin
    cnt_d = vbus_valid_in ? '0 : ((cnt_q < CNT_MAX) ? cnt_q + 1'b1 : cnt_q);
    err_d = ~vbus_valid_in & (~cfg_in.vbus_glitch_filter | (cnt_q >= CNT_MAX - 1'b1)); // see [R14]
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pwr_on_q <= 1'b0;
      fault_q <= 1'b0;
      epen_q <= 1'b0;
      oe_n_q <= 1'b0;
      err_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      pwr_on_q <= pwr_on_d;
      fault_q <= fault_d;
      epen_q <= epen_d;
      oe_n_q <= oe_n_d;
      err_q <= err_d;
      cnt_q <= cnt_d;
    end
  end

  assign ext_power_enable_out = epen_q;
  assign ext_power_enable_oe_n_out = oe_n_q;
  assign fault_out = fault_q;
  assign pwr_on_out = pwr_on_q;
  assign vbus_err_out = err_q;
endmodule

`default_nettype wire

// ===== rtl/usb_host_endpoint_power_ctrl.sv
// Purpose: Host-mode endpoint control and external power control registers
// Assumes: NUM_EP is a power of two, pins synchronous to mclk_in
// Notes: Endpoint settings are exported to the transaction engine
//
// Summary of operation
// [R1] Software forces toggle: false DATA0, true DATA1
// [R2] Separate IN/OUT toggles; endpoint zero has one
// [R3] Ping enable held for endpoint zero only
// [R4] Per-direction speed: low, full or high
// [R5] Clear exactly the named endpoint status bits
// [R6] Hub address readable per endpoint direction
// [R7] Hub word: address bits 0-6, port 8-14
// [R8] Hub write also records downstream device speed
// [R9] OTG parts switch to host mode on request
// [R10] Fault input polarity set by configuration
// [R11] Fault action: none, tristate, low or high
// [R12] Manual mode drives configured level on enable
// [R13] Session mode drives level while session enabled
// [R14] Optional filter ignores brief VBUS drops
// [R15] Power disable command deasserts power enable
// [R16] Power enable command asserts power enable
// [R17] Detection disable stops fault monitoring
// [R18] Software uses these controls only in host mode
// [R19] Detection enable starts fault monitoring
// [R20] Sensed fault sets a readable status flag
`default_nettype none

module usb_host_endpoint_power_ctrl
  import usb_host_ctrl_pkg::*;
#(
  parameter int NUM_EP = 8,
  parameter int STAT_W = 8,
  parameter bit OTG_CAPABLE = 1'b1,
  parameter int FILT_CYC = FILTER_CYC
) (
  input wire logic mclk_in,                          // System clock, 50 MHz
  input wire logic rst_in,                           // Async reset, active high
  input wire logic hsel_in,                          // AHB select
  input wire logic [31:0] haddr_in,                  // AHB address
  input wire logic [1:0] htrans_in,                  // AHB transfer type
  input wire logic hwrite_in,                        // AHB write
  input wire logic [2:0] hsize_in,                   // AHB size
  input wire logic [31:0] hwdata_in,                 // AHB write data
  input wire logic hready_in,                        // AHB ready in
  output logic [31:0] hrdata_out,                    // AHB read data
  output logic hreadyout_out,                        // AHB ready out
  output logic hresp_out,                            // AHB response
  input wire logic [NUM_EP*STAT_W-1:0] ep_stat_set_in, // Status set pulses
  input wire logic [2*NUM_EP-1:0] toggle_flip_in,    // Toggle advance pulses
  input wire logic power_fault_input,                // External fault pin
  input wire logic vbus_valid_in,                    // Raw VBUS valid
  output logic ext_power_enable_out,                 // Power enable pin
  output logic ext_power_enable_oe_n_out,            // Pin enable, low drives
  output logic vbus_err_out,                         // Filtered VBUS error
  output logic host_mode_out,                        // Host mode active
  output logic ping_en_out,                          // Ping tokens on endpoint zero
  output ep_cfg_t [2*NUM_EP-1:0] ep_cfg_out,         // Per slot settings
  output logic [NUM_EP*STAT_W-1:0] ep_stat_out       // Endpoint status bits
);
  localparam int EPW = $clog2(NUM_EP);
  localparam int SLW = EPW + 1;

  // ==========================================================
  // Slot decoding, shared by the write and read paths
  function automatic logic [SLW-1:0] slot(input logic [EPW-1:0] ep, input logic dir);
    return {ep, dir};
  endfunction

  // Endpoint zero keeps one toggle, so its direction is dropped
  function automatic logic [SLW-1:0] tgl_slot(input logic [EPW-1:0] ep, input logic dir);
    return (ep == '0) ? {ep, host_out_direction} : {ep, dir};
  endfunction

  reg_wr_t wr;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic host_q, host_d, ping_q, ping_d, det_q, det_d, ses_q, ses_d;
  logic sel_dir_q, sel_dir_d;
  logic [EPW-1:0] sel_ep_q, sel_ep_d;
  ep_cfg_t cfg_q [2*NUM_EP];
  ep_cfg_t cfg_d [2*NUM_EP];
  logic [STAT_W-1:0] stat_q [NUM_EP];
  logic [STAT_W-1:0] stat_d [NUM_EP];
  pwr_cfg_t pcfg_q, pcfg_d;
  logic en_cmd, dis_cmd, fault_clr, fault, pwr_on, vbus_err;
  logic [SLW-1:0] sel_slot, sel_tslot;

  // ==========================================================
  // Bus front end
  ahb_reg_slave u_bus (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .hsel_in(hsel_in),
    .haddr_in(haddr_in),
    .htrans_in(htrans_in),
    .hwrite_in(hwrite_in),
    .hsize_in(hsize_in),
    .hwdata_in(hwdata_in),
    .hready_in(hready_in),
    .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out),
    .wr_out(wr),
    .rd_addr_out(rd_addr),
    .rd_data_in(rd_data)
  );

  assign sel_slot = slot(sel_ep_q, sel_dir_q);
  assign sel_tslot = tgl_slot(sel_ep_q, sel_dir_q);

  // ==========================================================
  // Control and endpoint register next state
  // Software force wins over a hardware toggle advance in the same cycle
  always_comb begin
    host_d = host_q;
    ping_d = ping_q;
    det_d = det_q;
    ses_d = ses_q;
    sel_ep_d = sel_ep_q;
    sel_dir_d = sel_dir_q;
    pcfg_d = pcfg_q;
    en_cmd = 1'b0;
    dis_cmd = 1'b0;
    fault_clr = 1'b0;
    for (int i = 0; i < 2 * NUM_EP; i++) begin
      cfg_d[i] = cfg_q[i];
      if (toggle_flip_in[i]) begin
        cfg_d[i].toggle = ~cfg_q[i].toggle;
      end
    end
    if (wr.wr) begin
      case (wr.addr)
        OFF_MODE: begin
          if (OTG_CAPABLE) begin
            host_d = wr.data[MODE_HOST_BIT]; // see [R9]
          end
        end
        OFF_EP_SEL: begin
          sel_ep_d = wr.data[EPW-1:0];
          sel_dir_d = wr.data[SEL_DIR_BIT];
        end
        OFF_TOGGLE: cfg_d[sel_tslot].toggle = wr.data[TGL_BIT]; // see [R1] [R2]
        OFF_PING: ping_d = wr.data[PING_BIT]; // see [R3]
        OFF_SPEED: begin
          // Unused speed code leaves the setting alone; see [R4]
          if (wr.data[SPD_LSB+:2] != 2'b11) begin
            cfg_d[sel_slot].speed = ep_speed_t'(wr.data[SPD_LSB+:2]);
          end
        end
        OFF_HUB: begin
          cfg_d[sel_slot].hub_addr = wr.data[HUB_ADDR_LSB+:7]; // see [R7]
          cfg_d[sel_slot].hub_port = wr.data[HUB_PORT_LSB+:7];
          cfg_d[sel_slot].speed = wr.data[HUB_LS_BIT] ? endpoint_low_speed
                                                      : endpoint_full_speed; // see [R8]
        end
        OFF_PWR_CFG: begin
          pcfg_d = pwr_cfg_t'(wr.data[PWR_CFG_W-1:0]);
          // Session-driven enable exists only with OTG support
          if (!OTG_CAPABLE) begin
            pcfg_d.session_mode = 1'b0;
          end
        end
        OFF_PWR_CTRL: begin
          en_cmd = wr.data[PC_EN_BIT];
          dis_cmd = wr.data[PC_DIS_BIT];
          if (wr.data[PC_DET_ON_BIT]) begin
            det_d = 1'b1; // see [R19]
          end else if (wr.data[PC_DET_OFF_BIT]) begin
            det_d = 1'b0; // see [R17]
          end
          if (wr.data[PC_SES_ON_BIT]) begin
            ses_d = 1'b1;
          end else if (wr.data[PC_SES_OFF_BIT]) begin
            ses_d = 1'b0;
          end
        end
        OFF_PWR_STAT: fault_clr = wr.data[PS_FAULT_BIT];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Endpoint status: set by the engine, cleared by mask
  // A set in the clearing cycle survives
  always_comb begin
    for (int i = 0; i < NUM_EP; i++) begin
      stat_d[i] = ep_stat_set_in[i*STAT_W+:STAT_W] | stat_q[i];
      if (wr.wr && (wr.addr == OFF_EP_STAT) && (sel_ep_q == EPW'(i))) begin
        stat_d[i] = ep_stat_set_in[i*STAT_W+:STAT_W]
                    | (stat_q[i] & ~wr.data[STAT_W-1:0]); // see [R5]
      end
    end
  end

  // Register update
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      host_q <= ~OTG_CAPABLE;
      ping_q <= 1'b0;
      det_q <= 1'b0;
      ses_q <= 1'b0;
      sel_ep_q <= '0;
      sel_dir_q <= host_out_direction;
      pcfg_q <= PWR_CFG_RST;
      for (int i = 0; i < 2 * NUM_EP; i++) begin
        cfg_q[i] <= EP_CFG_RST;
      end
      for (int i = 0; i < NUM_EP; i++) begin
        stat_q[i] <= '0;
      end
    end else begin
      host_q <= host_d;
      ping_q <= ping_d;
      det_q <= det_d;
      ses_q <= ses_d;
      sel_ep_q <= sel_ep_d;
      sel_dir_q <= sel_dir_d;
      pcfg_q <= pcfg_d;
      cfg_q <= cfg_d;
      stat_q <= stat_d;
    end
  end

  // ==========================================================
  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_data = 32'h0000_0000;
    case (rd_addr)
      OFF_MODE: rd_data[MODE_HOST_BIT] = host_q;
      OFF_EP_SEL: begin
        rd_data[EPW-1:0] = sel_ep_q;
        rd_data[SEL_DIR_BIT] = sel_dir_q;
      end
      OFF_TOGGLE: rd_data[TGL_BIT] = cfg_q[sel_tslot].toggle; // see [R2]
      OFF_PING: rd_data[PING_BIT] = ping_q;
      OFF_SPEED: rd_data[SPD_LSB+:2] = cfg_q[sel_slot].speed;
      OFF_EP_STAT: rd_data[STAT_W-1:0] = stat_q[sel_ep_q];
      OFF_HUB: begin
        rd_data[HUB_ADDR_LSB+:7] = cfg_q[sel_slot].hub_addr; // see [R6]
        rd_data[HUB_PORT_LSB+:7] = cfg_q[sel_slot].hub_port;
        rd_data[HUB_LS_BIT] = (cfg_q[sel_slot].speed == endpoint_low_speed);
      end
      OFF_PWR_CFG: rd_data[PWR_CFG_W-1:0] = pcfg_q;
      OFF_PWR_STAT: begin
        rd_data[PS_FAULT_BIT] = fault;
        rd_data[PS_VBUS_ERR_BIT] = vbus_err;
        rd_data[PS_PWR_ON_BIT] = pwr_on;
        rd_data[PS_DET_BIT] = det_q;
        rd_data[PS_SES_BIT] = ses_q;
      end
      default: ;
    endcase
  end

  // ==========================================================
  // External power switch
  vbus_power_ctrl #(
    .FILT_CYC(FILT_CYC)
  ) u_pwr (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .cfg_in(pcfg_q),
    .host_mode_in(host_q),
    .en_cmd_in(en_cmd),
    .dis_cmd_in(dis_cmd),
    .det_en_in(det_q),
    .session_in(ses_q),
    .fault_clr_in(fault_clr),
    .power_fault_input(power_fault_input),
    .vbus_valid_in(vbus_valid_in),
    .ext_power_enable_out(ext_power_enable_out),
    .ext_power_enable_oe_n_out(ext_power_enable_oe_n_out),
    .fault_out(fault),
    .pwr_on_out(pwr_on),
    .vbus_err_out(vbus_err)
  );

  // ==========================================================
  // Exported state for the transaction engine
  assign host_mode_out = host_q;
  assign ping_en_out = ping_q;
  assign vbus_err_out = vbus_err;

  generate
    for (genvar g = 0; g < 2 * NUM_EP; g++) begin : g_cfg
      assign ep_cfg_out[g] = cfg_q[g];
    end
    for (genvar g = 0; g < NUM_EP; g++) begin : g_stat
      assign ep_stat_out[g*STAT_W+:STAT_W] = stat_q[g];
    end
  endgenerate
endmodule

`default_nettype wire

// ===== tb/usb_host_ctrl_properties.sv
// Purpose: Port checker
// Assumes: One clock
// Notes: Bound to the top
`default_nettype none

module usb_host_ctrl_checker
  import usb_host_ctrl_pkg::*;
#(
  parameter int NUM_EP = 8,
  parameter int STAT_W = 8
) (
  input wire logic mclk_in, // Clock
  input wire logic rst_in, // Reset
  input wire logic hsel_in, // Select
  input wire logic [1:0] htrans_in, // Transfer type
  input wire logic hwrite_in, // Write
  input wire logic hready_in, // Bus ready
  input wire logic hreadyout_out, // Slave ready
  input wire logic [NUM_EP*STAT_W-1:0] ep_stat_set_in, // Set pulses
  input wire logic [2*NUM_EP-1:0] toggle_flip_in, // Flip pulses
  input wire logic vbus_valid_in, // VBUS good
  input wire logic ext_power_enable_out, // Power pin
  input wire logic ext_power_enable_oe_n_out, // Pin enable
  input wire logic vbus_err_out, // VBUS error
  input wire logic host_mode_out, // Host mode
  input wire logic ping_en_out, // Ping enable
  input wire ep_cfg_t [2*NUM_EP-1:0] ep_cfg_out, // Slot settings
  input wire logic [NUM_EP*STAT_W-1:0] ep_stat_out // Status bits
);
  logic wdp_d, wdp_q, rd_req;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // ==========
  // Helpers
  assign rd_req = hsel_in && hready_in && htrans_in[1] && !hwrite_in;
  always_comb wdp_d = hsel_in && hready_in && htrans_in[1] && hwrite_in;
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) wdp_q <= 1'b0;
    else wdp_q <= wdp_d;
  end
  // ==========
  // Assertions
  a_write_no_wait: assert property (wdp_d |=> hreadyout_out)
    else $error("write stalled");
  a_read_one_wait: assert property (rd_req |=> !hreadyout_out ##1 hreadyout_out)
    else $error("read wait wrong");
  a_tri_pin_low: assert property (ext_power_enable_oe_n_out |-> !ext_power_enable_out)
    else $error("tristated pin not low");
  a_stat_set_wins: assert property (|ep_stat_set_in |=>
    (ep_stat_out & $past(ep_stat_set_in)) == $past(ep_stat_set_in))
    else $error("status set lost");
  a_stat_no_spont: assert property (
    (ep_stat_out & ~$past(ep_stat_out) & ~$past(ep_stat_set_in)) == '0)
    else $error("stray status set");
  a_flip_toggles: assert property (toggle_flip_in[2] && !wdp_q |=>
    ep_cfg_out[2].toggle != $past(ep_cfg_out[2].toggle))
    else $error("no toggle advance");
  a_ping_by_write: assert property ($changed(ping_en_out) |-> $past(wdp_q))
    else $error("stray ping change");
  a_mode_by_write: assert property ($changed(host_mode_out) |-> $past(wdp_q))
    else $error("stray mode change");
  a_vbus_ok_clears: assert property (vbus_valid_in |=> !vbus_err_out)
    else $error("stray vbus error");
  // Covers
  c_read: cover property (rd_req ##1 !hreadyout_out);
  c_tri: cover property (ext_power_enable_oe_n_out);
  c_verr: cover property ($rose(vbus_err_out));
endmodule

bind usb_host_endpoint_power_ctrl usb_host_ctrl_checker #(
  .NUM_EP(NUM_EP),
  .STAT_W(STAT_W)
) u_chk (.*);

`default_nettype wire

// ===== tb/vbus_switch_model.sv
// Purpose: Power switch model
// Assumes: Bench commands
// Notes: Fault pin idles inactive
`default_nettype none

module vbus_switch_model (
  input wire logic fault_in, // Raise a fault
  input wire logic act_high_in, // Fault pin active level
  input wire logic droop_in, // Pull VBUS down
  output logic fault_pin_out, // To fault input
  output logic vbus_ok_out // VBUS level good
);
  // Fault at chosen polarity
  assign fault_pin_out = fault_in ? act_high_in : !act_high_in;
  // Inrush droop drops VBUS valid
  assign vbus_ok_out = !droop_in;
endmodule

`default_nettype wire

// ===== tb/tb_usb_host_endpoint_power_ctrl.sv
// Purpose: Self-checking bench
// Assumes: Filter of 4 cycles
// Notes: Pins lag one register
`default_nettype none

module tb_usb_host_endpoint_power_ctrl import usb_host_ctrl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_in = 1'b0, rst_in = 1'b1, hsel_in = 1'b0, hwrite_in = 1'b0;
  logic [31:0] haddr_in = '0, hwdata_in = '0, hrdata_out;
  logic [1:0] htrans_in = '0;
  logic [63:0] ep_stat_set_in = '0, ep_stat_out;
  logic [15:0] toggle_flip_in = '0;
  logic flt_cmd = 1'b0, flt_pol = 1'b0, droop = 1'b0;
  logic hreadyout_out, power_fault_input, vbus_valid_in, ext_power_enable_out;
  logic ext_power_enable_oe_n_out, vbus_err_out, host_mode_out, ping_en_out;
  ep_cfg_t [15:0] ep_cfg_out;
  logic [1:0] act_pin [4] = '{2'b01, 2'b10, 2'b00, 2'b01};
  int miscompares = 0, cmp_count = 0;
  // ==========
  // Clock, DUT and switch model
  initial begin
    forever #10 mclk_in = ~mclk_in;
  end
  usb_host_endpoint_power_ctrl #(.FILT_CYC(4)) DUT (
    .*, .hsize_in(3'h2), .hready_in(hreadyout_out), .hresp_out()
  );
  vbus_switch_model partner (.fault_in(flt_cmd), .act_high_in(flt_pol), .droop_in(droop),
    .fault_pin_out(power_fault_input), .vbus_ok_out(vbus_valid_in));
  // ==========
  // Bus and compare tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_rdy;
    for (int n = 0; n < 20; n++) begin
      @(posedge mclk_in);
      if (hreadyout_out === 1'b1) return;
    end
    miscompares++;
    stop_test();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic w = 1'b1);
    hsel_in <= 1'b1;
    haddr_in <= {24'h0, a};
    htrans_in <= 2'h2;
    hwrite_in <= w;
    wait_rdy();
    htrans_in <= 2'h0;
    hwdata_in <= d;
    wait_rdy();
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    wr(a, 32'h0, 1'b0);
    chk(hrdata_out, e);
  endtask
  task automatic pin(input logic [1:0] e);
    repeat (2) @(posedge mclk_in);
    chk(32'({ext_power_enable_oe_n_out, ext_power_enable_out}), 32'(e));
  endtask
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ==========
  // Main sequence
  initial begin
    repeat (4) @(posedge mclk_in);
    rst_in <= 1'b0;
    rc(8'h3c, 32'h0);
    wr(OFF_MODE, 32'h1);
    rc(OFF_MODE, 32'h1);
    // Toggles per direction
    wr(OFF_EP_SEL, 32'h1);
    wr(OFF_TOGGLE, 32'h1);
    wr(OFF_EP_SEL, 32'h101);
    rc(OFF_TOGGLE, 32'h0);
    wr(OFF_EP_SEL, 32'h100);
    wr(OFF_TOGGLE, 32'h1);
    wr(OFF_EP_SEL, 32'h0);
    rc(OFF_TOGGLE, 32'h1);
    wr(OFF_PING, 32'h1);
    rc(OFF_PING, 32'h1);
    chk(32'(ping_en_out), 32'h1);
    wr(OFF_EP_SEL, 32'h101);
    for (int s = 0; s < 3; s++) begin
      wr(OFF_SPEED, 32'(s));
      rc(OFF_SPEED, 32'(s));
    end
    // Hub word, other slot untouched
    wr(OFF_HUB, 32'h12a55);
    rc(OFF_HUB, 32'h12a55);
    wr(OFF_EP_SEL, 32'h1);
    rc(OFF_HUB, 32'h0);
    // Set pulses, masked clear
    ep_stat_set_in[15:8] <= 8'ha5;
    toggle_flip_in <= 16'h4;
    @(posedge mclk_in);
    ep_stat_set_in <= '0;
    toggle_flip_in <= '0;
    wr(OFF_EP_STAT, 32'h81);
    rc(OFF_EP_STAT, 32'h24);
    rc(OFF_TOGGLE, 32'h0);
    // Manual enable at both levels
    pin(2'b01);
    wr(OFF_PWR_CTRL, 32'h1);
    pin(2'b00);
    wr(OFF_PWR_CFG, 32'h8);
    pin(2'b01);
    wr(OFF_PWR_CTRL, 32'h2);
    pin(2'b00);
    // Each fault action
    for (int a = 0; a < 4; a++) begin
      flt_pol <= a[0];
      wr(OFF_PWR_CFG, 32'(8 + a * 2 + a % 2));
      wr(OFF_PWR_CTRL, 32'h5);
      flt_cmd <= 1'b1;
      repeat (2) @(posedge mclk_in);
      pin(act_pin[a]);
      rc(OFF_PWR_STAT, 32'hd);
      flt_cmd <= 1'b0;
      wr(OFF_PWR_CTRL, 32'h8);
      wr(OFF_PWR_STAT, 32'h1);
      rc(OFF_PWR_STAT, 32'h4);
    end
    flt_cmd <= 1'b1;
    repeat (4) @(posedge mclk_in);
    rc(OFF_PWR_STAT, 32'h4);
    wr(OFF_PWR_CFG, 32'h18);
    wr(OFF_PWR_CTRL, 32'h10);
    pin(2'b01);
    wr(OFF_PWR_CTRL, 32'h20);
    pin(2'b00);
    // Droop, filter off then on; flag held steady when sampled
    droop <= 1'b1;
    repeat (2) @(posedge mclk_in);
    chk(32'(vbus_err_out), 32'h1);
    droop <= 1'b0;
    wr(OFF_PWR_CFG, 32'h20);
    droop <= 1'b1;
    repeat (3) @(posedge mclk_in);
    droop <= 1'b0;
    rc(OFF_PWR_STAT, 32'h4);
    droop <= 1'b1;
    repeat (6) @(posedge mclk_in);
    rc(OFF_PWR_STAT, 32'h6);
    stop_test();
  end
endmodule

`default_nettype wire
